// >>> inc/async_comm_interface_adapter_regs.vh
// Register codes, field positions, reset values and bit timing counts
`ifndef ASYNC_COMM_INTERFACE_ADAPTER_REGS_VH
`define ASYNC_COMM_INTERFACE_ADAPTER_REGS_VH
// Register-select codes {register_pick_high, register_pick_low}
`define RSEL_DATA         2'h0
`define RSEL_STATUS_RESET 2'h1
`define RSEL_MODE         2'h2
`define RSEL_SETUP        2'h3
// line_and_event_flags bit positions
`define ST_PARITY    0
`define ST_FRAMING   1
`define ST_OVERRUN   2
`define ST_RX_FULL   3
`define ST_TX_EMPTY  4
`define ST_CARRIER   5
`define ST_SET_READY 6
`define ST_IRQ       7
// mode_and_interrupt_setup fields
`define CMD_READY    0
`define CMD_RX_IRQ_OFF 1
`define CMD_TXC_LO   2
`define CMD_ECHO     4
`define CMD_PAR_EN   5
`define CMD_PAR_LO   6
`define TXC_IRQ_ON   2'h1
`define TXC_BREAK    2'h3
// rate_and_format_setup fields
`define CTL_RATE_LO  0
`define CTL_RX_INT   4
`define CTL_WL_LO    5
`define CTL_STOP     7
`define WL_FIVE      2'h3
`define WL_EIGHT     2'h0
// Reset values
`define MODE_RESET   8'h00
`define SETUP_RESET  8'h00
`define PROG_RESET_MASK 8'hE0
// Timing in 16x clock ticks
`define TICKS_BIT    6'h10
`define TICKS_HALF   6'h08
`define TICKS_STOP15 6'h18
`define TICKS_STOP2  6'h20
// Default half-period of the baud generator per rate-code step, in mclk
`define BAUD_UNIT_DEF 12'h008
`endif

// >>> rtl/async_comm_interface_adapter.v
// Asynchronous serial adapter: bus registers, transmitter, receiver, modem
`timescale 1ns/1ns
`default_nettype none
`include "async_comm_interface_adapter_regs.vh"
module async_comm_interface_adapter #(
	parameter [11:0] BAUD_UNIT = `BAUD_UNIT_DEF
) (
	input  wire       mclk,
	input  wire       srst,
	input  wire       power_on_clear_n,
	input  wire       phase2,
	input  wire       select_active_high,
	input  wire       select_active_low,
	input  wire       register_pick_low,
	input  wire       register_pick_high,
	input  wire       read_not_write,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output wire       data_oe,
	output wire       irq_out,
	output wire       irq_oe,
	input  wire       ext_clock,
	input  wire       receiver_16x_clock_pin_in,
	output reg        receiver_16x_clock_pin_out,
	output wire       receiver_16x_clock_pin_oe,
	output reg        txd,
	input  wire       rxd,
	input  wire       clear_to_send_n,
	input  wire       carrier_detect_n,
	input  wire       set_ready_n,
	output reg        request_to_send_n,
	output reg        terminal_ready_n
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_START = 3'h1;
	localparam [2:0] S_DATA = 3'h2;
	localparam [2:0] S_PAR = 3'h3;
	localparam [2:0] S_STOP = 3'h4;
	localparam [2:0] S_BREAK = 3'h5;
	localparam [2:0] S_MARK = 3'h6;

	// Keeps the bits of a character that the word length uses
	function [7:0] len_mask;
		input [1:0] wl;
		begin
			len_mask = 8'hFF >> wl;
		end
	endfunction

	function par_bit;
		input [7:0] d;
		input [1:0] wl;
		input [1:0] pm;
		reg         x;
		begin
			x = ^(d & len_mask(wl));
			case (pm)
				2'h0: par_bit = ~x;
				2'h1: par_bit = x;
				2'h2: par_bit = 1'b1;
				default: par_bit = 1'b0;
			endcase
		end
	endfunction

	wire rst = srst | ~power_on_clear_n;

	reg  [7:0] mode_q;
	reg  [7:0] setup_q;
	reg  [7:0] tx_hold_q;
	reg  [7:0] rx_hold_q;
	reg        pe_q, fe_q, ovr_q, rx_full_q, tx_empty_q;
	reg        dcd_q, dsr_q, irq_q, frozen_q, modem_irq_q;

	wire       ready = mode_q[`CMD_READY];
	wire [1:0] txc = mode_q[`CMD_TXC_LO+1:`CMD_TXC_LO];
	wire       echo = mode_q[`CMD_ECHO];
	wire       par_en = mode_q[`CMD_PAR_EN];
	wire [1:0] par_mode = mode_q[`CMD_PAR_LO+1:`CMD_PAR_LO];
	wire [3:0] rate = setup_q[`CTL_RATE_LO+3:`CTL_RATE_LO];
	wire [1:0] wl = setup_q[`CTL_WL_LO+1:`CTL_WL_LO];
	wire [2:0] last_bit = 3'h7 - {1'b0, wl};

	////////////////////////////////////////////////////////////////////////
	// Bus access: qualifiers held while phase 2 is high, acted on at its end

	reg        ph2_q, sel_q, rnw_q;
	reg  [1:0] rs_q;
	reg  [7:0] din_q;
	wire       sel = select_active_high & ~select_active_low;
	wire [1:0] rs = {register_pick_high, register_pick_low};
	wire       bus_end = ph2_q & ~phase2 & sel_q;
	wire       wr_end = bus_end & ~rnw_q;
	wire       rd_end = bus_end & rnw_q;
	wire       wr_tx = wr_end & (rs_q == `RSEL_DATA);
	wire       wr_prog = wr_end & (rs_q == `RSEL_STATUS_RESET);
	wire       rd_rx = rd_end & (rs_q == `RSEL_DATA);
	wire       rd_stat = rd_end & (rs_q == `RSEL_STATUS_RESET);

	// Bus output enable follows the pins so the bus is freed at once
	assign data_oe = sel & read_not_write & phase2;

	wire [7:0] status = {irq_q, dsr_q, dcd_q, tx_empty_q, rx_full_q,
		ovr_q, fe_q, pe_q};

	always @(posedge mclk)
	begin
		ph2_q <= phase2;
		if (phase2)
		begin
			sel_q <= sel;
			rnw_q <= read_not_write;
			rs_q <= rs;
			din_q <= data_in;
		end
		// Write data is taken late in phase 2, once it has settled
		case (rs)
			`RSEL_DATA: data_out <= rx_hold_q;
			`RSEL_STATUS_RESET: data_out <= status;
			`RSEL_MODE: data_out <= mode_q;
			default: data_out <= setup_q;
		endcase
		if (rst)
		begin
			ph2_q <= 1'b0;
			sel_q <= 1'b0;
			rnw_q <= 1'b1;
			rs_q <= 2'h0;
			din_q <= 8'h00;
			data_out <= 8'h00;
		end
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			mode_q <= `MODE_RESET;
			setup_q <= `SETUP_RESET;
			tx_hold_q <= 8'h00;
		end
		else if (wr_end)
		begin
			case (rs_q)
				`RSEL_DATA: tx_hold_q <= din_q;
				`RSEL_STATUS_RESET: mode_q <= mode_q & `PROG_RESET_MASK;
				`RSEL_MODE: mode_q <= din_q;
				default: setup_q <= din_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Baud generator and 16x ticks

	reg  [15:0] baud_cnt_q;
	reg         ext_q, rxc_q;
	wire [15:0] half_w = {12'h000, rate} * {4'h0, BAUD_UNIT};
	wire        gen_edge = (baud_cnt_q == 16'h0000);
	wire        tx_tick = (rate == 4'h0) ? (ext_clock & ~ext_q) :
		(gen_edge & ~receiver_16x_clock_pin_out);
	wire        rx_tick = setup_q[`CTL_RX_INT] ? tx_tick :
		(receiver_16x_clock_pin_in & ~rxc_q);

	assign receiver_16x_clock_pin_oe = setup_q[`CTL_RX_INT];

	always @(posedge mclk)
	begin
		ext_q <= ext_clock;
		rxc_q <= receiver_16x_clock_pin_in;
		if (rst)
		begin
			baud_cnt_q <= 16'h0000;
			receiver_16x_clock_pin_out <= 1'b0;
			ext_q <= 1'b0;
			rxc_q <= 1'b0;
		end
		else if (rate == 4'h0)
		begin
			baud_cnt_q <= 16'h0000;
			receiver_16x_clock_pin_out <= ext_clock;
		end
		else if (gen_edge)
		begin
			baud_cnt_q <= half_w - 16'h0001;
			receiver_16x_clock_pin_out <= ~receiver_16x_clock_pin_out;
		end
		else
			baud_cnt_q <= baud_cnt_q - 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter

	reg  [2:0] tx_st_q;
	reg  [5:0] tx_cnt_q;
	reg  [2:0] tx_bit_q;
	reg  [7:0] tx_sh_q;
	reg        tx_par_q, tx_line_q;
	reg  [5:0] stop_ticks;
	wire       tx_go = ready & ~clear_to_send_n;
	wire       tx_load = tx_tick & (tx_st_q == S_IDLE) & tx_go & ~tx_empty_q;

	always @*
	begin
		if (!setup_q[`CTL_STOP])
			stop_ticks = `TICKS_BIT;
		else if (wl == `WL_FIVE && !par_en)
			stop_ticks = `TICKS_STOP15;
		else if (wl == `WL_EIGHT && par_en)
			stop_ticks = `TICKS_BIT;
		else
			stop_ticks = `TICKS_STOP2;
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			tx_st_q <= S_IDLE;
			tx_cnt_q <= 6'h00;
			tx_bit_q <= 3'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
			tx_line_q <= 1'b1;
		end
		else if (tx_tick)
		begin
			tx_cnt_q <= tx_cnt_q - 6'h01;
			case (tx_st_q)
				S_IDLE:
				begin
					tx_line_q <= 1'b1;
					if (tx_load)
					begin
						tx_sh_q <= tx_hold_q & len_mask(wl);
						tx_par_q <= par_bit(tx_hold_q, wl, par_mode);
						tx_line_q <= 1'b0;
						tx_cnt_q <= `TICKS_BIT - 6'h01;
						tx_st_q <= S_START;
					end
					else if (txc == `TXC_BREAK && tx_go)
					begin
						tx_line_q <= 1'b0;
						tx_st_q <= S_BREAK;
					end
				end
				S_START:
					if (tx_cnt_q == 6'h00)
					begin
						tx_line_q <= tx_sh_q[0];
						tx_bit_q <= 3'h0;
						tx_cnt_q <= `TICKS_BIT - 6'h01;
						tx_st_q <= S_DATA;
					end
				S_DATA:
					if (tx_cnt_q == 6'h00)
					begin
						tx_cnt_q <= `TICKS_BIT - 6'h01;
						if (tx_bit_q != last_bit)
						begin
							tx_sh_q <= tx_sh_q >> 1;
							tx_line_q <= tx_sh_q[1];
							tx_bit_q <= tx_bit_q + 3'h1;
						end
						else if (par_en)
						begin
							tx_line_q <= tx_par_q;
							tx_st_q <= S_PAR;
						end
						else
						begin
							tx_line_q <= 1'b1;
							tx_cnt_q <= stop_ticks - 6'h01;
							tx_st_q <= S_STOP;
						end
					end
				S_PAR:
					if (tx_cnt_q == 6'h00)
					begin
						tx_line_q <= 1'b1;
						tx_cnt_q <= stop_ticks - 6'h01;
						tx_st_q <= S_STOP;
					end
				S_STOP:
					if (tx_cnt_q == 6'h00)
						tx_st_q <= S_IDLE;
				S_BREAK:
					// Leaving break sends one stop bit first
					if (txc != `TXC_BREAK)
					begin
						tx_line_q <= 1'b1;
						tx_cnt_q <= `TICKS_BIT - 6'h01;
						tx_st_q <= S_STOP;
					end
				default: tx_st_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver and echo delay line

	reg  [2:0] rx_st_q;
	reg  [5:0] rx_cnt_q;
	reg  [2:0] rx_bit_q;
	reg  [7:0] rx_sh_q;
	reg        rx_par_q;
	reg  [7:0] echo_q;
	wire [7:0] rx_word = rx_sh_q >> wl;
	wire       rx_done = rx_tick & (rx_st_q == S_STOP) & (rx_cnt_q == 6'h00);
	wire       rx_pe = par_en & ~par_mode[1] &
		(rx_par_q != par_bit(rx_word, wl, par_mode));

	always @(posedge mclk)
	begin
		if (rst)
		begin
			rx_st_q <= S_IDLE;
			rx_cnt_q <= 6'h00;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_par_q <= 1'b0;
			echo_q <= 8'hFF;
		end
		else if (rx_st_q == S_MARK)
		begin
			// A break line ends reception until mark returns
			if (rxd)
				rx_st_q <= S_IDLE;
		end
		else if (rx_tick)
		begin
			echo_q <= {echo_q[6:0], rxd};
			rx_cnt_q <= rx_cnt_q - 6'h01;
			case (rx_st_q)
				S_IDLE:
					// A character in progress completes even if disabled
					if (ready && !rxd)
					begin
						rx_cnt_q <= `TICKS_HALF - 6'h01;
						rx_st_q <= S_START;
					end
				S_START:
					if (rx_cnt_q == 6'h00)
					begin
						rx_cnt_q <= `TICKS_BIT - 6'h01;
						rx_bit_q <= 3'h0;
						rx_st_q <= rxd ? S_IDLE : S_DATA;
					end
				S_DATA:
					if (rx_cnt_q == 6'h00)
					begin
						rx_sh_q <= {rxd, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						rx_cnt_q <= `TICKS_BIT - 6'h01;
						if (rx_bit_q == last_bit)
							rx_st_q <= par_en ? S_PAR : S_STOP;
					end
				S_PAR:
					if (rx_cnt_q == 6'h00)
					begin
						rx_par_q <= rxd;
						rx_cnt_q <= `TICKS_BIT - 6'h01;
						rx_st_q <= S_STOP;
					end
				S_STOP:
					if (rx_cnt_q == 6'h00)
						rx_st_q <= rxd ? S_IDLE : S_MARK;
				default: rx_st_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status, modem lines and interrupt

	wire rx_irq_en = ready & ~mode_q[`CMD_RX_IRQ_OFF];
	wire tx_irq_en = ready & (txc == `TXC_IRQ_ON) & ~echo;
	wire rx_store = rx_done & ~rx_full_q;
	wire modem_diff = (dcd_q != carrier_detect_n) | (dsr_q != set_ready_n);
	wire modem_evt = ~frozen_q & modem_diff & ready;
	// Parity, framing and overrun do not appear here
	wire irq_set = (rx_done & rx_irq_en) | (tx_load & tx_irq_en) |
		modem_evt;

	assign irq_out = 1'b0;
	assign irq_oe = irq_q;

	always @(posedge mclk)
	begin
		if (rst)
		begin
			rx_hold_q <= 8'h00;
			pe_q <= 1'b0;
			fe_q <= 1'b0;
			ovr_q <= 1'b0;
			rx_full_q <= 1'b0;
			tx_empty_q <= 1'b1;
			dcd_q <= carrier_detect_n;
			dsr_q <= set_ready_n;
			frozen_q <= 1'b0;
			modem_irq_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			if (rx_store)
			begin
				rx_hold_q <= rx_word;
				pe_q <= rx_pe;
				fe_q <= ~rxd;
			end
			if (rx_store)
				rx_full_q <= 1'b1;
			else if (rd_rx)
				rx_full_q <= 1'b0;
			if (rx_done & rx_full_q)
				ovr_q <= 1'b1;
			else if (rd_rx | wr_prog)
				ovr_q <= 1'b0;
			if (tx_load)
				tx_empty_q <= 1'b1;
			else if (wr_tx)
				tx_empty_q <= 1'b0;
			// Modem bits track freely while disabled or after a status read
			if (!frozen_q)
			begin
				dcd_q <= carrier_detect_n;
				dsr_q <= set_ready_n;
			end
			if (modem_evt)
				frozen_q <= 1'b1;
			else if (rd_stat | ~ready)
				frozen_q <= 1'b0;
			if (modem_evt)
				modem_irq_q <= 1'b1;
			else if (rd_stat | wr_prog)
				modem_irq_q <= 1'b0;
			if (irq_set)
				irq_q <= 1'b1;
			else if (rd_stat | (wr_prog & modem_irq_q))
				irq_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Modem outputs and serial line

	always @(posedge mclk)
	begin
		if (rst)
		begin
			txd <= 1'b1;
			request_to_send_n <= 1'b1;
			terminal_ready_n <= 1'b1;
		end
		else
		begin
			terminal_ready_n <= ~ready;
			request_to_send_n <= (txc == 2'h0) & ~echo;
			if (clear_to_send_n || !ready)
				txd <= 1'b1;
			else if (echo)
				txd <= echo_q[7];
			else
				txd <= tx_line_q;
		end
	end

endmodule // async_comm_interface_adapter
`default_nettype wire

// >>> testbench/async_comm_interface_adapter_checker.sv
// Checker: bus, modem-control and reset relations at the adapter ports
`timescale 1ns/1ns
`default_nettype none
module async_comm_interface_adapter_checker (
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic       power_on_clear_n,
	input wire logic       phase2,
	input wire logic       select_active_high,
	input wire logic       select_active_low,
	input wire logic       register_pick_low,
	input wire logic       register_pick_high,
	input wire logic       read_not_write,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       irq_oe,
	input wire logic       receiver_16x_clock_pin_oe,
	input wire logic       txd,
	input wire logic       clear_to_send_n,
	input wire logic       request_to_send_n,
	input wire logic       terminal_ready_n
);
	wire        rst = srst | ~power_on_clear_n;
	wire  [1:0] rsel = {register_pick_high, register_pick_low};
	logic       ph_q, sel_q, rnw_q;
	logic [1:0] rs_q;
	logic [7:0] dat_q, mode_q, ctl_q;
	// An access acts when phase2 falls, using the last values seen high
	wire        wr = ph_q & ~phase2 & sel_q & ~rnw_q;
	wire        wr_cmd = wr & (rs_q == 2'h1 || rs_q == 2'h2);
	wire        wr_ctl = wr & (rs_q == 2'h3);
	always @(posedge mclk)
	begin
		ph_q <= phase2;
		if (phase2)
		begin
			sel_q <= select_active_high & ~select_active_low;
			rnw_q <= read_not_write;
			rs_q <= rsel;
			dat_q <= data_in;
		end
	end
	// Shadow copies; a programmed reset keeps only the parity field
	always @(posedge mclk)
	begin
		if (rst)
		begin
			mode_q <= 8'h00;
			ctl_q <= 8'h00;
		end
		else if (wr_cmd)
			mode_q <= (rs_q == 2'h2) ? dat_q : (mode_q & 8'hE0);
		else if (wr_ctl)
			ctl_q <= dat_q;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_oe;
		data_oe == (phase2 & read_not_write & select_active_high
			& ~select_active_low);
	endproperty
	a_oe: assert property (p_oe)
		else $error("data bus drive wrong");
	property p_cts;
		clear_to_send_n |=> txd;
	endproperty
	a_cts: assert property (p_cts)
		else $error("line not at mark while clear-to-send high");
	property p_dtr;
		wr_cmd |-> ##2 (terminal_ready_n == !mode_q[0]);
	endproperty
	a_dtr: assert property (p_dtr)
		else $error("terminal ready level wrong");
	property p_rts;
		wr_cmd |-> ##2
			(request_to_send_n == (mode_q[3:2] == 2'h0 && !mode_q[4]));
	endproperty
	a_rts: assert property (p_rts)
		else $error("request to send level wrong");
	property p_rst;
		disable iff (1'b0) rst |=> txd && request_to_send_n
			&& terminal_ready_n && !irq_oe && data_out == 8'h00;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not at reset state");
	property p_mode_rd;
		phase2 && $past(phase2) && rsel == 2'h2 && $past(rsel) == 2'h2
			|-> data_out == mode_q;
	endproperty
	a_mode_rd: assert property (p_mode_rd)
		else $error("command readback wrong");
	property p_ctl_rd;
		phase2 && $past(phase2) && rsel == 2'h3 && $past(rsel) == 2'h3
			|-> data_out == ctl_q;
	endproperty
	a_ctl_rd: assert property (p_ctl_rd)
		else $error("control readback wrong");
	property p_irqoff;
		!mode_q[0] && !$past(mode_q[0]) && !irq_oe |=> !irq_oe;
	endproperty
	a_irqoff: assert property (p_irqoff)
		else $error("interrupt raised while disabled");
	property p_rxc;
		wr_ctl |-> ##2 (receiver_16x_clock_pin_oe == ctl_q[4]);
	endproperty
	a_rxc: assert property (p_rxc)
		else $error("receive clock pin direction wrong");
endmodule // async_comm_interface_adapter_checker
bind async_comm_interface_adapter async_comm_interface_adapter_checker u_chk (
	.mclk(mclk), .srst(srst), .power_on_clear_n(power_on_clear_n),
	.phase2(phase2), .select_active_high(select_active_high),
	.select_active_low(select_active_low),
	.register_pick_low(register_pick_low),
	.register_pick_high(register_pick_high),
	.read_not_write(read_not_write), .data_in(data_in),
	.data_out(data_out), .data_oe(data_oe), .irq_oe(irq_oe),
	.receiver_16x_clock_pin_oe(receiver_16x_clock_pin_oe), .txd(txd),
	.clear_to_send_n(clear_to_send_n),
	.request_to_send_n(request_to_send_n),
	.terminal_ready_n(terminal_ready_n)
);
`default_nettype wire

// >>> testbench/modem_model.sv
// Modem model: drives receive data and line status, captures frames
`timescale 1ns/1ns
`default_nettype none
module modem_model #(
	parameter int BIT = 32
) (
	input  wire logic mclk,
	input  wire logic txd,
	output var logic  rxd,
	output var logic  cts_n,
	output var logic  dcd_n,
	output var logic  dsr_n
);
	initial
	begin
		rxd = 1'b1;
		cts_n = 1'b0;
		dcd_n = 1'b0;
		dsr_n = 1'b1;
	end
	// Start bit, n bits LSB first, one stop bit, then a short idle gap
	task automatic send(input logic [8:0] v, input int n);
		int i;
		for (i = 0; i <= n; i++)
		begin
			@(posedge mclk) #1 rxd = (i == 0) ? 1'b0 : v[i - 1];
			repeat (BIT - 1) @(posedge mclk);
		end
		@(posedge mclk) #1 rxd = 1'b1;
		repeat (BIT + 4) @(posedge mclk);
	endtask
	// Bounded wait for a start bit, then mid-bit samples and stop check
	task automatic grab(input int n, output logic [8:0] v, output bit ok);
		int i;
		v = 9'h000;
		ok = 1'b0;
		// Line is read just after each edge, once the design has moved it
		for (i = 0; i < 40 * BIT && !ok; i++)
			@(posedge mclk) #1 ok = (txd === 1'b0);
		if (ok)
		begin
			repeat (BIT / 2) @(posedge mclk);
			#1 ok = (txd === 1'b0);
			for (i = 0; i < n; i++)
			begin
				repeat (BIT) @(posedge mclk);
				#1 v[i] = txd;
			end
			repeat (BIT) @(posedge mclk);
			#1 ok = ok && (txd === 1'b1);
		end
	endtask
endmodule // modem_model
`default_nettype wire

// >>> testbench/test_async_comm_interface_adapter.sv
// Testbench: register accesses and modem traffic through the adapter
`timescale 1ns/1ns
`default_nettype none
`include "async_comm_interface_adapter_regs.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module test_async_comm_interface_adapter;
	logic       mclk, srst, poc_n, phase2, cs, cs_n, rs0, rs1, rnw, xclk;
	logic [7:0] din, q;
	logic [8:0] v9;
	bit         ok9;
	wire        irq_oe, rxc_oe, txd, rxd, cts_n, dcd_n, dsr_n, rts_n, dtr_n;
	wire  [7:0] dout;
	int         n_fail = 0, num_checks = 0, k;
	async_comm_interface_adapter #(
		.BAUD_UNIT(12'h001)
	) u_async_comm_interface_adapter (
		.mclk(mclk), .srst(srst), .power_on_clear_n(poc_n),
		.phase2(phase2), .select_active_high(cs), .select_active_low(cs_n),
		.register_pick_low(rs0), .register_pick_high(rs1),
		.read_not_write(rnw), .data_in(din), .data_out(dout), .data_oe(),
		.irq_out(), .irq_oe(irq_oe), .ext_clock(xclk),
		.receiver_16x_clock_pin_in(xclk), .receiver_16x_clock_pin_out(),
		.receiver_16x_clock_pin_oe(rxc_oe), .txd(txd), .rxd(rxd),
		.clear_to_send_n(cts_n), .carrier_detect_n(dcd_n),
		.set_ready_n(dsr_n), .request_to_send_n(rts_n),
		.terminal_ready_n(dtr_n)
	);
	modem_model #(
		.BIT(32)
	) u_modem (
		.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .dcd_n(dcd_n),
		.dsr_n(dsr_n)
	);
	always #5 mclk = ~mclk;
	// External 16x clock: one rising edge every second mclk
	always @(posedge mclk) #1 xclk = ~xclk;
	////////////////////////////////////////////////////////////////
	task automatic tick;
		@(posedge mclk) #1;
	endtask
	task automatic close_out;
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Phase2 high for three edges so read data has settled before taken
	task automatic bus(input logic [1:0] rs, input logic rw,
		input logic [7:0] d, input logic sel, output logic [7:0] r);
		tick;
		{rs1, rs0} = rs;
		rnw = rw;
		din = d;
		cs = sel;
		cs_n = ~sel;
		phase2 = 1'b1;
		repeat (2) tick;
		r = dout;
		tick;
		phase2 = 1'b0;
		repeat (2) tick;
	endtask
	task automatic wr(input logic [1:0] rs, input logic [7:0] d);
		bus(rs, 1'b0, d, 1'b1, q);
	endtask
	task automatic rdc(input logic [1:0] rs, input logic [7:0] e);
		logic [7:0] r;
		bus(rs, 1'b1, 8'h00, 1'b1, r);
		`CHK(r, e)
	endtask
	task automatic wait_irq;
		int i;
		for (i = 0; i < 200 && irq_oe !== 1'b1; i++)
			tick;
		`CHK(irq_oe, 1'b1)
		if (irq_oe !== 1'b1)
			close_out;
	endtask
	task automatic txg(input int n, input logic [8:0] e);
		logic [8:0] v;
		bit         ok;
		u_modem.grab(n, v, ok);
		`CHK(ok, 1'b1)
		if (!ok)
			close_out;
		`CHK(v, e)
		repeat (40) tick;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		{mclk, srst, poc_n, phase2, cs, cs_n, rs0, rs1, rnw} = 9'b011000000;
		din = 8'h00;
		xclk = 1'b0;
		repeat (3) tick;
		srst = 1'b0;
		rdc(`RSEL_STATUS_RESET, 8'h50);
		rdc(`RSEL_MODE, 8'h00);
		rdc(`RSEL_SETUP, 8'h00);
		wr(`RSEL_SETUP, 8'h11);
		rdc(`RSEL_SETUP, 8'h11);
		`CHK(rxc_oe, 1'b1)
		bus(`RSEL_MODE, 1'b0, 8'h0F, 1'b0, q);
		rdc(`RSEL_MODE, 8'h00);
		wr(`RSEL_MODE, 8'h09);
		rdc(`RSEL_MODE, 8'h09);
		`CHK({dtr_n, rts_n}, 2'b00)
		wr(`RSEL_DATA, 8'hA5);
		txg(8, 9'h0A5);
		rdc(`RSEL_STATUS_RESET, 8'h50);
		u_modem.send(9'h03C, 8);
		wait_irq;
		rdc(`RSEL_STATUS_RESET, 8'hD8);
		`CHK(irq_oe, 1'b0)
		rdc(`RSEL_DATA, 8'h3C);
		rdc(`RSEL_STATUS_RESET, 8'h50);
		u_modem.dcd_n = 1'b1;
		wait_irq;
		u_modem.dcd_n = 1'b0;
		repeat (4) tick;
		rdc(`RSEL_STATUS_RESET, 8'hF0);
		wait_irq;
		rdc(`RSEL_STATUS_RESET, 8'hD0);
		rdc(`RSEL_STATUS_RESET, 8'h50);
		wr(`RSEL_MODE, 8'h11);
		`CHK(rts_n, 1'b0)
		fork
			u_modem.send(9'h0C3, 8);
			txg(8, 9'h0C3);
		join
		rdc(`RSEL_STATUS_RESET, 8'hD8);
		rdc(`RSEL_DATA, 8'hC3);
		wr(`RSEL_MODE, 8'h05);
		u_modem.cts_n = 1'b1;
		wr(`RSEL_DATA, 8'h55);
		repeat (100) tick;
		rdc(`RSEL_STATUS_RESET, 8'h40);
		u_modem.cts_n = 1'b0;
		txg(8, 9'h055);
		`CHK(irq_oe, 1'b1)
		rdc(`RSEL_STATUS_RESET, 8'hD0);
		// Break holds the line low until the field leaves code 11
		wr(`RSEL_MODE, 8'h0D);
		repeat (4) tick;
		`CHK(txd, 1'b0)
		wr(`RSEL_MODE, 8'h09);
		repeat (4) tick;
		`CHK(txd, 1'b1)
		// Two stop bits: the queued character must not start early
		wr(`RSEL_SETUP, 8'h91);
		wr(`RSEL_DATA, 8'h96);
		fork
			u_modem.grab(9, v9, ok9);
			begin
				repeat (80) tick;
				wr(`RSEL_DATA, 8'h69);
			end
		join
		`CHK({ok9, v9}, 10'h396)
		txg(8, 9'h069);
		// Rate code 0 and the external receive clock both run from xclk
		wr(`RSEL_SETUP, 8'h00);
		`CHK(rxc_oe, 1'b0)
		wr(`RSEL_DATA, 8'hB4);
		txg(8, 9'h0B4);
		u_modem.send(9'h04B, 8);
		wait_irq;
		rdc(`RSEL_STATUS_RESET, 8'hD8);
		rdc(`RSEL_DATA, 8'h4B);
		// Every word length, then every parity kind at five bits
		for (k = 0; k < 4; k++)
		begin
			wr(`RSEL_SETUP, {1'b0, 2'(k), 5'h11});
			wr(`RSEL_DATA, 8'hF3);
			txg(8 - k, {1'b0, 8'hF3 & (8'hFF >> k)});
		end
		for (k = 0; k < 4; k++)
		begin
			wr(`RSEL_MODE, {2'(k), 6'h29});
			wr(`RSEL_DATA, 8'hF3);
			txg(6, {3'h0, (k == 1 || k == 2), 5'h13});
		end
		wr(`RSEL_MODE, 8'h69);
		u_modem.send(9'h01D, 6);
		wait_irq;
		rdc(`RSEL_STATUS_RESET, 8'hD8);
		rdc(`RSEL_DATA, 8'h1D);
		u_modem.send(9'h03D, 6);
		wait_irq;
		rdc(`RSEL_STATUS_RESET, 8'hD9);
		rdc(`RSEL_DATA, 8'h1D);
		wr(`RSEL_STATUS_RESET, 8'hFF);
		rdc(`RSEL_MODE, 8'h60);
		rdc(`RSEL_SETUP, 8'h71);
		`CHK(dtr_n, 1'b1)
		u_modem.dsr_n = 1'b0;
		repeat (50) tick;
		`CHK(irq_oe, 1'b0)
		poc_n = 1'b0;
		tick;
		poc_n = 1'b1;
		rdc(`RSEL_SETUP, 8'h00);
		rdc(`RSEL_STATUS_RESET, 8'h10);
		close_out;
	end
endmodule // test_async_comm_interface_adapter
`default_nettype wire
